// file: aoc_pkg.sv
// aoc_pkg: constants for the converter output configuration registers
package aoc_pkg;

    // ------------------------------------------------------------
    // register indexes (byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_OFFSET   = 8'h10;
    localparam logic [7:0] IDX_FORMAT   = 8'h14;
    localparam logic [7:0] IDX_STRENGTH = 8'h15;
    localparam logic [7:0] IDX_PHASE    = 8'h16;
    localparam logic [7:0] IDX_DELAY    = 8'h17;
    localparam logic [7:0] IDX_SPAN     = 8'h18;
    localparam logic [7:0] IDX_PATTERN  = 8'h19;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OFFSET   = 8'h00;
    localparam logic [7:0] RST_FORMAT   = 8'h00;
    localparam logic [7:0] RST_STRENGTH = 8'h22;
    localparam logic [7:0] RST_PHASE    = 8'h00;
    localparam logic [7:0] RST_DELAY    = 8'h00;
    localparam logic [7:0] RST_SPAN     = 8'hE0;
    localparam logic [7:0] RST_PATTERN  = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FMT_SUPPLY_LSB  = 6;
    localparam int FMT_DISABLE_BIT = 4;
    localparam int FMT_CODE_LSB    = 0;
    localparam int STR_DCO33_LSB   = 6;
    localparam int STR_DCO18_LSB   = 4;
    localparam int STR_DAT33_LSB   = 2;
    localparam int STR_DAT18_LSB   = 0;
    localparam int PH_POL_BIT      = 7;
    localparam int PH_SEL_LSB      = 0;
    localparam int DLY_DCO_EN_BIT  = 7;
    localparam int DLY_DAT_EN_BIT  = 5;
    localparam int DLY_SEL_LSB     = 0;
    localparam int SPAN_SEL_LSB    = 0;

    // ------------------------------------------------------------
    // encodings and counts
    // ------------------------------------------------------------
    localparam logic [1:0] FMT_TWOS   = 2'h1;
    localparam logic [1:0] FMT_GRAY   = 2'h2;
    localparam logic [1:0] SUPPLY_18V = 2'h2;
    localparam int         PHASE_MAX  = 6;
    localparam int         WAIT_CYCLES = 1;

endpackage

// file: aoc_output_config.sv
// aoc_output_config: output shaping registers and sample output path
//
// Behaviour
// - add signed 8-bit offset, +127 to -128 LSB, to every sample
// - format code 01 twos complement, 10 gray, 00 and 11 offset binary
// - mode register, reset 0x00, holds supply level, disable, format
// - four 2-bit drive fields pick one to four stripes; reset 0x22
// - 3-bit phase code delays output clock by 0 to 6 input cycles
// - phase and polarity touch only output clock; polarity inverts it
// - fine delay code applies to clock or data per enable; reset 0x00
`timescale 1ns/1ps

module aoc_output_config #(
    parameter int DATA_W = 10,
    parameter int ADDR_W = 10
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] address_i,
    input  wire logic              read_i,
    input  wire logic              write_i,
    input  wire logic [31:0]       writedata_i,
    input  wire logic [3:0]        byteenable_i,
    output logic      [31:0]       readdata_o,
    output logic                   waitrequest_o,
    input  wire logic [DATA_W-1:0] sample_i,
    input  wire logic              divider_clk_i,
    output logic      [DATA_W-1:0] data_o,
    output logic                   data_oe_o,
    output logic                   sample_clock_output_o,
    output logic      [1:0]        output_supply_o,
    output logic      [1:0]        clock_strength_o,
    output logic      [1:0]        data_strength_o,
    output logic      [2:0]        clock_fine_delay_o,
    output logic      [2:0]        data_fine_delay_o,
    output logic      [2:0]        reference_span_o,
    output logic      [7:0]        first_pattern_low_byte_o
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // clamp rather than wrap: a wrapped code would flip full scale
    function automatic logic [DATA_W-1:0] add_trim(
        input logic [DATA_W-1:0] s,
        input logic [7:0]        t
    );
        logic signed [DATA_W+1:0] sum;
        sum = $signed({2'b00, s}) + $signed({{(DATA_W-6){t[7]}}, t});
        if (sum < 0)
            add_trim = '0;
        else if (sum[DATA_W])
            add_trim = '1;
        else
            add_trim = sum[DATA_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] encode(
        input logic [DATA_W-1:0] b,
        input logic [1:0]        f
    );
        case (f)
            aoc_pkg::FMT_TWOS: encode = {~b[DATA_W-1], b[DATA_W-2:0]};
            aoc_pkg::FMT_GRAY: encode = b ^ (b >> 1);
            default:           encode = b;
        endcase
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] sample_offset_trim;
    logic [7:0] output_format_control;
    logic [7:0] driver_strength_control;
    logic [7:0] output_clock_phase;
    logic [7:0] output_fine_delay;
    logic [7:0] reference_span_select;
    logic [7:0] first_pattern_low_byte;

    wire        req      = read_i | write_i;
    wire        word_ok  = address_i[1:0] == 2'b00;
    wire [7:0]  idx      = address_i[ADDR_W-1:2];
    wire        accepted = req & ~waitrequest_o;
    wire        wr_en    = accepted & write_i & word_ok & byteenable_i[0];
    wire [7:0]  wbyte    = writedata_i[7:0];

    wire hit_offset   = word_ok & (idx == aoc_pkg::IDX_OFFSET);
    wire hit_format   = word_ok & (idx == aoc_pkg::IDX_FORMAT);
    wire hit_strength = word_ok & (idx == aoc_pkg::IDX_STRENGTH);
    wire hit_phase    = word_ok & (idx == aoc_pkg::IDX_PHASE);
    wire hit_delay    = word_ok & (idx == aoc_pkg::IDX_DELAY);
    wire hit_span     = word_ok & (idx == aoc_pkg::IDX_SPAN);
    wire hit_pattern  = word_ok & (idx == aoc_pkg::IDX_PATTERN);

    // unmapped addresses read zero and ignore writes
    wire [7:0] rd_mux =
        hit_offset   ? sample_offset_trim      :
        hit_format   ? output_format_control   :
        hit_strength ? driver_strength_control :
        hit_phase    ? output_clock_phase      :
        hit_delay    ? output_fine_delay       :
        hit_span     ? reference_span_select   :
        hit_pattern  ? first_pattern_low_byte  : 8'h00;

    // one wait cycle per request, then a single accept edge
    wire next_waitrequest = ~(req & waitrequest_o);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h0000_0000;
        end else begin
            waitrequest_o <= next_waitrequest;
            if (req & waitrequest_o & read_i)
                readdata_o <= {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_offset_trim      <= aoc_pkg::RST_OFFSET;
            output_format_control   <= aoc_pkg::RST_FORMAT;
            driver_strength_control <= aoc_pkg::RST_STRENGTH;
            output_clock_phase      <= aoc_pkg::RST_PHASE;
            output_fine_delay       <= aoc_pkg::RST_DELAY;
            reference_span_select   <= aoc_pkg::RST_SPAN;
            first_pattern_low_byte  <= aoc_pkg::RST_PATTERN;
        end else if (wr_en) begin
            if (hit_offset)   sample_offset_trim      <= wbyte;
            if (hit_format)   output_format_control   <= wbyte;
            if (hit_strength) driver_strength_control <= wbyte;
            if (hit_phase)    output_clock_phase      <= wbyte;
            if (hit_delay)    output_fine_delay       <= wbyte;
            if (hit_span)     reference_span_select   <= wbyte;
            if (hit_pattern)  first_pattern_low_byte  <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire [1:0] fmt_code  = output_format_control[aoc_pkg::FMT_CODE_LSB+:2];
    wire [1:0] supply    =
        output_format_control[aoc_pkg::FMT_SUPPLY_LSB+:2];
    wire       out_off   = output_format_control[aoc_pkg::FMT_DISABLE_BIT];
    wire       low_rail  = supply == aoc_pkg::SUPPLY_18V;
    wire [1:0] next_clk_str = low_rail ?
        driver_strength_control[aoc_pkg::STR_DCO18_LSB+:2] :
        driver_strength_control[aoc_pkg::STR_DCO33_LSB+:2];
    wire [1:0] next_dat_str = low_rail ?
        driver_strength_control[aoc_pkg::STR_DAT18_LSB+:2] :
        driver_strength_control[aoc_pkg::STR_DAT33_LSB+:2];
    wire       polarity  = output_clock_phase[aoc_pkg::PH_POL_BIT];
    wire [2:0] phase_raw = output_clock_phase[aoc_pkg::PH_SEL_LSB+:3];
    // code 111 is not defined; held at the longest documented phase
    wire [2:0] phase_sel = (phase_raw > 3'(aoc_pkg::PHASE_MAX)) ?
        3'(aoc_pkg::PHASE_MAX) : phase_raw;
    wire [2:0] fine_code = output_fine_delay[aoc_pkg::DLY_SEL_LSB+:3];
    wire       clk_dly_en = output_fine_delay[aoc_pkg::DLY_DCO_EN_BIT];
    wire       dat_dly_en = output_fine_delay[aoc_pkg::DLY_DAT_EN_BIT];

    // ------------------------------------------------------------
    // sample path: latching ignores every clock output setting
    // ------------------------------------------------------------
    logic [DATA_W-1:0] trimmed;
    wire  [DATA_W-1:0] next_trimmed = add_trim(sample_i, sample_offset_trim);
    wire  [DATA_W-1:0] next_data    = encode(trimmed, fmt_code);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trimmed   <= '0;
            data_o    <= '0;
            data_oe_o <= 1'b0;
        end else begin
            trimmed   <= next_trimmed;
            data_o    <= next_data;
            data_oe_o <= ~out_off;
        end
    end

    // ------------------------------------------------------------
    // output clock: divider level through a phase tap line
    // ------------------------------------------------------------
    logic [aoc_pkg::PHASE_MAX:0] phase_line;
    wire  [aoc_pkg::PHASE_MAX:0] next_phase_line =
        {phase_line[aoc_pkg::PHASE_MAX-1:0], divider_clk_i};
    wire  next_clock_out = phase_line[phase_sel] ^ polarity;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_line            <= '0;
            sample_clock_output_o <= 1'b0;
        end else begin
            phase_line            <= next_phase_line;
            sample_clock_output_o <= next_clock_out;
        end
    end

    // ------------------------------------------------------------
    // pad controls
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_supply_o          <= 2'h0;
            clock_strength_o         <= 2'h0;
            data_strength_o          <= 2'h0;
            clock_fine_delay_o       <= 3'h0;
            data_fine_delay_o        <= 3'h0;
            reference_span_o         <= 3'h0;
            first_pattern_low_byte_o <= 8'h00;
        end else begin
            output_supply_o    <= supply;
            clock_strength_o   <= next_clk_str;
            data_strength_o    <= next_dat_str;
            clock_fine_delay_o <= clk_dly_en ? fine_code : 3'h0;
            data_fine_delay_o  <= dat_dly_en ? fine_code : 3'h0;
            reference_span_o   <=
                reference_span_select[aoc_pkg::SPAN_SEL_LSB+:3];
            first_pattern_low_byte_o <= first_pattern_low_byte;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    bus_answer_a: assert property (
        req & waitrequest_o |=> ~waitrequest_o)
        else $error("request not answered after one wait cycle");

    bus_release_a: assert property (
        ~waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");

    trim_add_a: assert property (
        $stable(sample_offset_trim) && sample_offset_trim == 8'h00
        |=> trimmed == $past(sample_i))
        else $error("zero offset changed the sample");

    trim_neg_a: assert property (
        sample_offset_trim == 8'hFF && sample_i > 0
        |=> trimmed == $past(sample_i) - 1'b1)
        else $error("offset of minus one not applied");

    fmt_twos_a: assert property (
        fmt_code == aoc_pkg::FMT_TWOS
        |=> data_o[DATA_W-1] == ~$past(trimmed[DATA_W-1]))
        else $error("twos complement sign bit wrong");

    fmt_gray_a: assert property (
        fmt_code == aoc_pkg::FMT_GRAY
        |=> data_o[DATA_W-1] == $past(trimmed[DATA_W-1])
            && data_o[0] == ^$past(trimmed[1:0]))
        else $error("gray code output wrong");

    out_disable_a: assert property (
        wr_en && hit_format && wbyte[aoc_pkg::FMT_DISABLE_BIT]
        |=> ##1 !data_oe_o)
        else $error("output disable not applied two cycles later");

    strength_rst_a: assert property (
        $past(rst_i) |-> driver_strength_control == aoc_pkg::RST_STRENGTH)
        else $error("drive strength reset value wrong");

    phase_zero_a: assert property (
        phase_sel == 3'h0 && $stable(output_clock_phase)
        |=> sample_clock_output_o
            == ($past(divider_clk_i, 2) ^ $past(polarity)))
        else $error("output clock phase or polarity wrong");

    fine_gate_a: assert property (
        !clk_dly_en |=> clock_fine_delay_o == 3'h0)
        else $error("clock fine delay active while disabled");

    write_apply_a: assert property (
        wr_en && hit_offset |=> sample_offset_trim == $past(wbyte))
        else $error("offset write did not take effect");

    // ------------------------------------------------------------
    // assertions: clamping, formats, pad controls, clock phase, resets and writes
    // ------------------------------------------------------------
    // saturation means the trim never moves a sample the wrong way
    trim_high_a: assert property (
        !sample_offset_trim[7] |=> trimmed >= $past(sample_i))
        else $error("positive offset lowered the sample");

    trim_low_a: assert property (
        sample_offset_trim[7] |=> trimmed <= $past(sample_i))
        else $error("negative offset raised the sample");

    fmt_plain_a: assert property (
        (fmt_code == 2'h0 || fmt_code == 2'h3)
        |=> data_o == $past(trimmed))
        else $error("offset binary output altered");

    twos_rest_a: assert property (
        fmt_code == aoc_pkg::FMT_TWOS
        |=> data_o[DATA_W-2:0] == $past(trimmed[DATA_W-2:0]))
        else $error("twos complement low bits wrong");

    oe_follow_a: assert property (
        !out_off |=> data_oe_o)
        else $error("data outputs not driven while enabled");

    supply_low_a: assert property (
        supply == aoc_pkg::SUPPLY_18V
        |=> output_supply_o == aoc_pkg::SUPPLY_18V)
        else $error("low supply level not exported");

    format_rst_a: assert property (
        $past(rst_i) |-> output_format_control == aoc_pkg::RST_FORMAT)
        else $error("output mode reset value wrong");

    clk_str_lo_a: assert property (
        low_rail |=> clock_strength_o
            == $past(driver_strength_control[aoc_pkg::STR_DCO18_LSB+:2]))
        else $error("low supply clock drive field not used");

    clk_str_hi_a: assert property (
        !low_rail |=> clock_strength_o
            == $past(driver_strength_control[aoc_pkg::STR_DCO33_LSB+:2]))
        else $error("high supply clock drive field not used");

    dat_str_a: assert property (
        !low_rail |=> data_strength_o
            == $past(driver_strength_control[aoc_pkg::STR_DAT33_LSB+:2]))
        else $error("high supply data drive field not used");

    phase_six_a: assert property (
        phase_raw == 3'h6 && !polarity
        |=> sample_clock_output_o == $past(divider_clk_i, 8))
        else $error("six cycle output clock phase wrong");

    dat_gate_a: assert property (
        !dat_dly_en |=> data_fine_delay_o == 3'h0)
        else $error("data fine delay active while disabled");

    fine_pass_a: assert property (
        clk_dly_en |=> clock_fine_delay_o == $past(fine_code))
        else $error("clock fine delay code not passed on");

    delay_rst_a: assert property (
        $past(rst_i) |-> output_fine_delay == aoc_pkg::RST_DELAY)
        else $error("fine delay reset value wrong");

    format_write_a: assert property (
        wr_en && hit_format |=> output_format_control == $past(wbyte))
        else $error("format write did not take effect");

    write_cv: cover property (write_i ##1 ~waitrequest_o);
    read_cv:  cover property (read_i && hit_format ##1 ~waitrequest_o);
    gray_cv:  cover property (fmt_code == aoc_pkg::FMT_GRAY [*3]);
    phase_cv: cover property (phase_sel == 3'h6 && polarity);
    offs_cv:  cover property (wr_en && hit_offset && wbyte == 8'hFF);

endmodule

// file: aoc_capture_model.sv
// aoc_capture_model: capture logic standing behind the parallel outputs
`timescale 1ns/1ps

module aoc_capture_model #(
    parameter int DATA_W = 10
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              enable_i,
    output logic      [DATA_W-1:0] captured_o,
    output logic      [15:0]       count_o
);
    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    // words are only taken while the pins are driven; a released bus
    // keeps the last captured word so stale data never looks fresh
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            captured_o <= '0;
            count_o    <= 16'h0000;
        end else if (enable_i) begin
            captured_o <= data_i;
            count_o    <= count_o + 16'h0001;
        end
    end
endmodule

// file: aoc_testbench.sv
// aoc_testbench: register and output path checks for the output config
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    failures++; $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end end

module testbench;
    logic        clk_i, rst_i, read_i, write_i, divider_clk_i, waitrequest_o;
    logic [9:0]  address_i, sample_i, data_o, cap;
    logic [31:0] writedata_i, readdata_o, rd;
    logic [3:0]  byteenable_i;
    logic        data_oe_o, sample_clock_output_o;
    logic [1:0]  output_supply_o, clock_strength_o, data_strength_o;
    logic [2:0]  clock_fine_delay_o, data_fine_delay_o, reference_span_o;
    logic [7:0]  first_pattern_low_byte_o;
    logic [15:0] cap_count;
    int          failures, tests_run, n0, n6, n7, n_hold;
    logic        idle_out;

    aoc_output_config dut (.clk_i(clk_i), .rst_i(rst_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .byteenable_i(byteenable_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .sample_i(sample_i), .divider_clk_i(divider_clk_i),
        .data_o(data_o), .data_oe_o(data_oe_o),
        .sample_clock_output_o(sample_clock_output_o),
        .output_supply_o(output_supply_o),
        .clock_strength_o(clock_strength_o),
        .data_strength_o(data_strength_o),
        .clock_fine_delay_o(clock_fine_delay_o),
        .data_fine_delay_o(data_fine_delay_o),
        .reference_span_o(reference_span_o),
        .first_pattern_low_byte_o(first_pattern_low_byte_o));

    aoc_capture_model cap_model (.clk_i(clk_i), .rst_i(rst_i),
        .data_i(data_o), .enable_i(data_oe_o), .captured_o(cap),
        .count_o(cap_count));

    // ------------------------------------------------------------
    // bus access
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // no fixed latency assumed: hold until waitrequest seen low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge clk_i);
        address_i    <= {idx, 2'b00};
        writedata_i  <= {24'hFFFFFF, d};
        byteenable_i <= be;
        write_i      <= wr;
        read_i       <= !wr;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 20);
        rd = readdata_o;
        write_i <= 1'b0;
        read_i  <= 1'b0;
        if (n >= 20) begin
            failures++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hF);
        repeat (4) @(posedge clk_i);
    endtask

    task automatic chk_reg(input logic [7:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 8'h00, 4'hF);
        `CHK("register", {24'h000000, ex}, rd)
    endtask

    // edges from divider rise to output clock change
    task automatic lag(output int n);
        divider_clk_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        divider_clk_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (sample_clock_output_o === idle_out && n < 30);
        if (n >= 30) begin
            failures++;
            summarize();
        end
    endtask

    function automatic logic [9:0] enc(input logic [9:0] b,
                                       input logic [1:0] f);
        case (f)
            2'h1:    return {~b[9], b[8:0]};
            2'h2:    return b ^ (b >> 1);
            default: return b;
        endcase
    endfunction

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1; read_i = 1'b0; write_i = 1'b0; address_i = 10'h000;
        writedata_i = 32'h00000000; byteenable_i = 4'hF;
        sample_i = 10'h200; divider_clk_i = 1'b0; idle_out = 1'b0;
        failures = 0; tests_run = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_reg(8'h10, 8'h00);
        chk_reg(8'h14, 8'h00);
        chk_reg(8'h15, 8'h22);
        chk_reg(8'h16, 8'h00);
        chk_reg(8'h17, 8'h00);
        chk_reg(8'h18, 8'hE0);
        chk_reg(8'h19, 8'h00);
        chk_reg(8'h11, 8'h00);
        `CHK("clk_str", 2'b00, clock_strength_o)
        `CHK("dat_str", 2'b00, data_strength_o)
        `CHK("oe", 1'b1, data_oe_o)
        wr(8'h19, 8'h5A);
        chk_reg(8'h19, 8'h5A);
        `CHK("pattern", 8'h5A, first_pattern_low_byte_o)
        bus(1'b1, 8'h19, 8'h33, 4'hE);
        chk_reg(8'h19, 8'h5A);
        wr(8'h18, 8'hE5);
        `CHK("span", 3'h5, reference_span_o)
        wr(8'h10, 8'h7F);
        `CHK("offset_pos", 10'h27F, data_o)
        `CHK("captured", 10'h27F, cap)
        wr(8'h10, 8'h80);
        `CHK("offset_neg", 10'h180, data_o)
        wr(8'h10, 8'hFF);
        `CHK("offset_m1", 10'h1FF, data_o)
        sample_i <= 10'h3F0;
        wr(8'h10, 8'h7F);
        `CHK("clamp_hi", 10'h3FF, data_o)
        sample_i <= 10'h010;
        wr(8'h10, 8'h80);
        `CHK("clamp_lo", 10'h000, data_o)
        sample_i <= 10'h200;
        repeat (3) @(posedge clk_i);
        `CHK("offset_back", 10'h180, data_o)
        for (int f = 0; f < 4; f++) begin
            wr(8'h14, 8'(f));
            `CHK("format", enc(10'h180, 2'(f)), data_o)
        end
        wr(8'h14, 8'h10);
        `CHK("disabled", 1'b0, data_oe_o)
        n_hold = int'(cap_count);
        repeat (3) @(posedge clk_i);
        `CHK("cap_hold", n_hold, int'(cap_count))
        wr(8'h14, 8'h80);
        `CHK("oe_back", 1'b1, data_oe_o)
        `CHK("supply", 2'b10, output_supply_o)
        wr(8'h15, 8'h1B);
        `CHK("clk_str18", 2'b01, clock_strength_o)
        `CHK("dat_str18", 2'b11, data_strength_o)
        wr(8'h14, 8'h00);
        `CHK("clk_str33", 2'b00, clock_strength_o)
        `CHK("dat_str33", 2'b10, data_strength_o)
        wr(8'h17, 8'hA5);
        `CHK("clk_dly", 3'h5, clock_fine_delay_o)
        `CHK("dat_dly", 3'h5, data_fine_delay_o)
        wr(8'h17, 8'h86);
        `CHK("clk_dly2", 3'h6, clock_fine_delay_o)
        `CHK("dat_dly2", 3'h0, data_fine_delay_o)
        lag(n0);
        `CHK("phase0", 3, n0)
        wr(8'h16, 8'h06);
        lag(n6);
        `CHK("phase6", 6, n6 - n0)
        `CHK("data_kept", 10'h180, data_o)
        wr(8'h16, 8'h07);
        lag(n7);
        `CHK("phase7", n6, n7)
        wr(8'h16, 8'h80);
        idle_out = 1'b1;
        lag(n7);
        `CHK("polarity", n0, n7)
        `CHK("inverted", 1'b0, sample_clock_output_o)
        `CHK("data_pol", 10'h180, data_o)
        summarize();
    end
endmodule
